// File: dv/sdr_media_model.sv
`timescale 1ns/10ps
module sdr_media_model (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   start,
  input  wire logic                   sel,
  input  wire sdr_pkg::sdr_img_resp_t imgResp,
  output sdr_pkg::sdr_img_req_t       imgReq,
  output logic                        done,
  output logic [11:0]                 lastIdx
);
  import sdr_pkg::*;
  logic [7:0]  img [0:2047];  // Captured list sector, as the channel records it
  logic [11:0] capIdx;        // Next capture slot
  logic        active;        // Sector walk in progress

  // Offset walker: one byte request per cycle over a whole sector
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active <= 1'b0;
      imgReq <= '0;
    end else if (start && !active) begin
      active <= 1'b1;
      imgReq <= '{1'b1, sel, 16'h0000};
    end else if (active && imgReq.offset == 16'h07ff) begin
      // Released: offset toggles so a stale value never looks valid
      active <= 1'b0;
      imgReq.valid <= 1'b0;
      imgReq.offset <= ~imgReq.offset;
    end else if (active) begin
      imgReq.offset <= imgReq.offset + 16'h0001;
    end else begin
      imgReq.offset <= ~imgReq.offset;
      imgReq.selSecondary <= ~imgReq.selSecondary;
    end
  end

  // Capture side: store bytes in arrival order, note where the end mark fell
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      capIdx <= 12'h000;
      done <= 1'b0;
      lastIdx <= 12'h000;
    end else if (start && !active) begin
      capIdx <= 12'h000;
      done <= 1'b0;
      lastIdx <= 12'h000;
    end else if (imgResp.valid) begin
      img[capIdx] <= imgResp.data;
      capIdx <= capIdx + 12'h001;
      if (imgResp.last) begin
        lastIdx <= capIdx;
      end
      if (capIdx == 12'h7ff) begin
        done <= 1'b1;
      end
    end
  end
endmodule

// File: dv/tb_sdr_sector_defect_remap.sv
`timescale 1ns/10ps
module tb_sdr_sector_defect_remap;
  import sdr_pkg::*;
  logic          clk;
  logic          nrst;
  sdr_cmd_t      cmd;
  sdr_base_t     base;        // Spare start of every group
  sdr_xlate_t    xlateReq;
  sdr_img_req_t  imgReq;
  sdr_cmd_resp_t cmdResp;
  sdr_xlate_t    xlateResp;
  sdr_img_resp_t imgResp;
  logic          busy;
  logic [4:0]    pdlCount;
  logic [3:0]    sdlCount;
  logic          start;
  logic          sel;
  logic          done;
  logic [11:0]   lastIdx;
  int            errorCnt;
  int            compares;
  logic [7:0]    expImg [0:2047];        // Expected list sector
  bit            primMap [sdr_addr_t];   // Slipped addresses, kept sorted by key
  sdr_addr_t     secMap [sdr_addr_t];    // Defective to replacement

  // Four spares per group keeps exhaustion reachable in a few commands
  sdr_sector_defect_remap #(.SPARES_PER_GROUP(12'h004)) u_sdr_sector_defect_remap (
    .clk(clk), .nrst(nrst), .cmd(cmd), .groupSpareBase(base), .xlateReq(xlateReq), .imgReq(imgReq),
    .cmdResp(cmdResp), .xlateResp(xlateResp), .imgResp(imgResp), .busy(busy), .pdlCount(pdlCount),
    .sdlCount(sdlCount));
  sdr_media_model u_sdr_media_model (
    .clk(clk), .nrst(nrst), .start(start), .sel(sel), .imgResp(imgResp), .imgReq(imgReq),
    .done(done), .lastIdx(lastIdx));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One command, bounded wait for its answer, then judge outcome and replacement
  task automatic cmdChk(input sdr_op_t op, input logic cert, input logic [3:0] grp, input sdr_addr_t a,
                        input sdr_stat_t es, input sdr_addr_t er);
    int n;
    n = 0;
    cmd = '{1'b1, op, cert, grp, a};
    @(posedge clk);
    #1;
    cmd.valid = 1'b0;
    while (cmdResp.valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) begin
      errorCnt++;
      summarize();
    end
    chk("cmd stat", {29'h0, cmdResp.stat}, {29'h0, es});
    chk("cmd repl", cmdResp.repl, er);
  endtask

  // Fetch a whole list sector through the channel model and compare every byte
  task automatic imgChk(input logic s);
    int n;
    int k;
    for (int i = 0; i < 2048; i++) expImg[i] = PAD_BYTE;
    k = s ? 16 : 4;
    if (!s) begin
      {expImg[0], expImg[1], expImg[2], expImg[3]} = {PDL_ID0, PDL_ID1, 16'(primMap.num())};
      foreach (primMap[a]) begin
        {expImg[k], expImg[k+1], expImg[k+2], expImg[k+3]} = a;
        k += 4;
      end
    end else begin
      {expImg[0], expImg[1], expImg[2], expImg[3]} = SDL_ID;
      {expImg[4], expImg[5], expImg[6]} = 24'(8 * secMap.num());
      {expImg[7], expImg[8], expImg[9]} = SDL_FIXED;
      {expImg[10], expImg[11], expImg[12], expImg[13]} = 32'h00000000;
      {expImg[14], expImg[15]} = 16'(secMap.num());
      foreach (secMap[a]) begin
        {expImg[k], expImg[k+1], expImg[k+2], expImg[k+3], expImg[k+4], expImg[k+5], expImg[k+6],
         expImg[k+7]} = {a, secMap[a]};
        k += 8;
      end
    end
    sel = s;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 3000) begin
      errorCnt++;
      summarize();
    end
    for (int i = 0; i < 2048; i++) begin
      chk($sformatf("image %0d byte %0d", s, i), {24'h0, u_sdr_media_model.img[i]}, {24'h0, expImg[i]});
    end
    chk("end mark", {20'h0, lastIdx}, 32'h000007ff);
  endtask

  // Slip over sorted entries first, then follow any redirect
  task automatic xlateChk(input sdr_addr_t a);
    int n;
    logic sawBusy;
    sdr_addr_t cur;
    cur = a;
    foreach (primMap[p]) if (p <= cur) cur++;
    if (secMap.exists(cur)) cur = secMap[cur];
    n = 0;
    sawBusy = 1'b0;
    xlateReq = '{1'b1, a};
    do begin
      @(posedge clk);
      #1;
      n++;
      sawBusy |= busy;
    end while (xlateResp.valid !== 1'b1 && n < 40);
    xlateReq.valid = 1'b0;
    if (n == 40) begin
      errorCnt++;
      summarize();
    end
    chk("xlate addr", xlateResp.addr, cur);
    chk("walk busy", {31'h0, sawBusy}, 32'h1);
  endtask

  // Certification slips, a repeat refused, a loaded list slipped too
  task automatic slipScenario();
    cmdChk(OP_DEFECT, 1'b1, 4'h0, 32'h00000305, ST_SLIPPED, 32'h00000305);
    cmdChk(OP_DEFECT, 1'b1, 4'h0, 32'h00000102, ST_SLIPPED, 32'h00000102);
    cmdChk(OP_DEFECT, 1'b1, 4'h0, 32'h00000102, ST_IN_PRIMARY, 32'h00000102);
    cmdChk(OP_LOAD_PRIMARY, 1'b0, 4'h4, 32'h00000501, ST_SLIPPED, 32'h00000501);
    primMap[32'h102] = 1'b1;
    primMap[32'h305] = 1'b1;
    primMap[32'h501] = 1'b1;
    chk("primary count", {27'h0, pdlCount}, 32'h3);
  endtask

  // Own-group spares in order, never for a slipped address, re-failure redirected
  task automatic linearScenario();
    cmdChk(OP_DEFECT, 1'b0, 4'h1, 32'h00000220, ST_LINEAR, base[1]);
    cmdChk(OP_DEFECT, 1'b0, 4'h1, 32'h00000210, ST_LINEAR, base[1] + 32'h1);
    cmdChk(OP_DEFECT, 1'b0, 4'h0, 32'h00000305, ST_IN_PRIMARY, 32'h00000305);
    cmdChk(OP_DEFECT, 1'b0, 4'h1, base[1], ST_REREPLACED, base[1] + 32'h2);
    cmdChk(OP_DEFECT, 1'b0, 4'h1, 32'h00000210, ST_DONE, 32'h00000210);
    secMap[32'h210] = base[1] + 32'h1;
    secMap[32'h220] = base[1] + 32'h2;
    chk("secondary count", {28'h0, sdlCount}, 32'h2);
  endtask

  // Group runs dry, may borrow only after the lender is certified
  task automatic exhaustScenario();
    for (int i = 1; i <= 4; i++) begin
      cmdChk(OP_DEFECT, 1'b1, 4'h2, 32'h400 + 32'(i), ST_SLIPPED, 32'h400 + 32'(i));
      primMap[32'h400 + 32'(i)] = 1'b1;
    end
    cmdChk(OP_DEFECT, 1'b1, 4'h2, 32'h00000405, ST_NO_SPARE, 32'h00000405);
    cmdChk(OP_CERT_DONE, 1'b0, 4'h3, 32'h00000000, ST_DONE, 32'h00000000);
    cmdChk(OP_DEFECT, 1'b1, 4'h2, 32'h00000405, ST_LINEAR, base[3]);
    secMap[32'h405] = base[3];
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    cmd = '0;
    xlateReq = '0;
    start = 1'b0;
    sel = 1'b0;
    errorCnt = 0;
    compares = 0;
    for (int g = 0; g < NUM_GROUPS; g++) base[g] = 32'h00100000 + 32'(g) * 32'h100;
    repeat (3) @(posedge clk);
    #1;
    nrst = 1'b1;
    @(posedge clk);
    #1;
    chk("reset primary count", {27'h0, pdlCount}, 32'h0);
    imgChk(1'b0);
    imgChk(1'b1);
    slipScenario();
    linearScenario();
    exhaustScenario();
    imgChk(1'b0);
    imgChk(1'b1);
    xlateChk(32'h00000101);
    xlateChk(32'h00000102);
    xlateChk(32'h0000020f);
    xlateChk(32'h0000021f);
    xlateChk(32'h00000400);
    summarize();
  end
endmodule

// File: inc/sdr_pkg.sv
// Overview of operation
// - Certification slips each group on its own
// - Defective data sector slips; logged in primary
// - Defective spare logged in primary, spares shrink
// - Exhausted group borrows only certified group spares
// - Replacement: own group spare first, else other
// - Primary-listed address never enters secondary list
// - Failed replacement gets a new spare in its existing entry
// - Uncertified disks still skip primary-listed sectors
// - Writes skip primary entries, follow secondary redirects
// - Defective sectors are never read or written
// - Primary list always present, sorted ascending
// - Primary list minimal sectors, tail padded FF
// - Primary header only in first sector
// - Empty primary: zero count, FF from byte four
// - Primary header 00 01 then count MSB first
// - Entry: three-byte track MSB first, one-byte sector
// - Secondary entry: defective then replacement address
// - Secondary entries ascending by defective address
// - Secondary list minimal sectors, tail padded FF
// - Sixteen-byte secondary header only in first sector
// - Secondary header constants and three-byte length
// - Secondary count in bytes 14-15, entries at 16
// - Total replaced sectors capped at 8976
package sdr_pkg;
  localparam int NUM_GROUPS = 12;                 // Rewritable groups
  localparam int PDL_DEPTH  = 16;                 // Primary list capacity
  localparam int SDL_DEPTH  = 8;                  // Secondary list capacity
  localparam logic [13:0] MAX_REPLACED = 14'h2310;  // 8976 sectors
  localparam logic [15:0] SECTOR_BYTES  = 16'h0800; // 2048-byte sector
  localparam int          SECTOR_SHIFT  = 11;
  localparam logic [15:0] PDL_HDR_BYTES = 16'h0004;
  localparam logic [15:0] SDL_HDR_BYTES = 16'h0010;
  localparam int          PDL_ENT_SHIFT = 2;      // Four bytes per entry
  localparam int          SDL_ENT_SHIFT = 3;      // Eight bytes per entry
  localparam logic [7:0]  PAD_BYTE      = 8'hff;
  localparam logic [7:0]  PDL_ID0       = 8'h00;
  localparam logic [7:0]  PDL_ID1       = 8'h01;
  localparam logic [31:0] SDL_ID        = 32'h00020001; // Bytes 0..3
  localparam logic [23:0] SDL_FIXED     = 24'h000201;   // Bytes 7..9
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

  typedef logic [31:0] sdr_addr_t;                // Track[23:0], sector[7:0]
  typedef logic [NUM_GROUPS-1:0][31:0] sdr_base_t;

  typedef enum logic [1:0] {OP_DEFECT, OP_CERT_DONE, OP_LOAD_PRIMARY} sdr_op_t;
  typedef enum logic [2:0] {ST_SLIPPED, ST_LINEAR, ST_REREPLACED, ST_IN_PRIMARY,
                            ST_NO_SPARE, ST_LIMIT, ST_DONE} sdr_stat_t;

  typedef struct packed {
    logic      valid;
    sdr_op_t   op;
    logic      certifying;
    logic [3:0] group;
    sdr_addr_t addr;
  } sdr_cmd_t;

  typedef struct packed {
    logic      valid;
    sdr_stat_t stat;
    sdr_addr_t repl;
  } sdr_cmd_resp_t;

  typedef struct packed {
    logic      valid;
    sdr_addr_t addr;
  } sdr_xlate_t;

  typedef struct packed {
    logic        valid;
    logic        selSecondary;
    logic [15:0] offset;
  } sdr_img_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } sdr_img_resp_t;
endpackage

// File: src/sdr_sector_defect_remap.sv
`timescale 1ns/10ps
module sdr_sector_defect_remap #(
  parameter logic [11:0] SPARES_PER_GROUP = 12'h200  // Spare sectors per group
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire sdr_pkg::sdr_cmd_t      cmd,
  input  wire sdr_pkg::sdr_base_t     groupSpareBase,
  input  wire sdr_pkg::sdr_xlate_t    xlateReq,
  input  wire sdr_pkg::sdr_img_req_t  imgReq,
  output sdr_pkg::sdr_cmd_resp_t      cmdResp,
  output sdr_pkg::sdr_xlate_t         xlateResp,
  output sdr_pkg::sdr_img_resp_t      imgResp,
  output logic                        busy,
  output logic [4:0]                  pdlCount,
  output logic [3:0]                  sdlCount
);
  import sdr_pkg::*;

  typedef enum {X_IDLE, X_WALK, X_SDL} sdr_xstate_t;
  typedef enum {ACT_NONE, ACT_PDL, ACT_SDL_NEW, ACT_SDL_FIX} sdr_act_t;

  sdr_addr_t           primary_defect_list [PDL_DEPTH];     // Primary list, ascending
  sdr_addr_t           sdlDef [SDL_DEPTH];  // Secondary defective keys
  sdr_addr_t           sdlRep [SDL_DEPTH];  // Secondary replacements
  logic [11:0]         used [NUM_GROUPS];   // Spares consumed per group
  logic [NUM_GROUPS-1:0] certified;         // Group spare layout known
  logic [13:0]         replTotal;           // Sectors replaced so far
  sdr_xstate_t         xState;
  sdr_addr_t           cur;                 // Physical target being walked
  logic [4:0]          idx;                 // Walk position in primary list

  logic                cmdTaken;
  logic                xlateTaken;
  logic [PDL_DEPTH-1:0] pdlHit;             // Address already primary
  logic [PDL_DEPTH-1:0] pdlGt;              // Slot must shift up
  logic [SDL_DEPTH-1:0] sdlKeyHit;
  logic [SDL_DEPTH-1:0] sdlRepHit;
  logic [SDL_DEPTH-1:0] sdlGt;
  logic [SDL_DEPTH-1:0] curHit;             // Translation redirect match
  sdr_addr_t           next_pdl [PDL_DEPTH];
  sdr_addr_t           next_sdlDef [SDL_DEPTH];
  sdr_addr_t           next_sdlRep [SDL_DEPTH];

  // Entry-wise compares and sorted insertion
  genvar gi;
  generate
    for (gi = 0; gi < PDL_DEPTH; gi++) begin : g_pdl
      assign pdlHit[gi] = (5'(gi) < pdlCount) && (primary_defect_list[gi] == cmd.addr);
      // Unused slots count as larger so the new entry lands at the end
      assign pdlGt[gi]  = (5'(gi) >= pdlCount) || (primary_defect_list[gi] > cmd.addr);
      if (gi == 0) begin : g_first
        assign next_pdl[gi] = pdlGt[gi] ? cmd.addr : primary_defect_list[gi];
      end else begin : g_rest
        assign next_pdl[gi] = !pdlGt[gi] ? primary_defect_list[gi] : (pdlGt[gi-1] ? primary_defect_list[gi-1] : cmd.addr);
      end
    end
    for (gi = 0; gi < SDL_DEPTH; gi++) begin : g_sdl
      assign sdlKeyHit[gi] = (4'(gi) < sdlCount) && (sdlDef[gi] == cmd.addr);
      assign sdlRepHit[gi] = (4'(gi) < sdlCount) && (sdlRep[gi] == cmd.addr);
      assign curHit[gi]    = (4'(gi) < sdlCount) && (sdlDef[gi] == cur);
      assign sdlGt[gi]     = (4'(gi) >= sdlCount) || (sdlDef[gi] > cmd.addr);
      if (gi == 0) begin : g_first
        assign next_sdlDef[gi] = sdlGt[gi] ? cmd.addr : sdlDef[gi];
        assign next_sdlRep[gi] = sdlGt[gi] ? 32'h0 : sdlRep[gi];
      end else begin : g_rest
        assign next_sdlDef[gi] = !sdlGt[gi] ? sdlDef[gi] : (sdlGt[gi-1] ? sdlDef[gi-1] : cmd.addr);
        assign next_sdlRep[gi] = !sdlGt[gi] ? sdlRep[gi] : (sdlGt[gi-1] ? sdlRep[gi-1] : 32'h0);
      end
    end
  endgenerate

  // Commands win the shared slot; translations wait for an idle cycle
  assign cmdTaken   = cmd.valid && !busy;
  assign xlateTaken = xlateReq.valid && !busy && !cmd.valid;

  // Decide what a defect report does
  sdr_act_t  act;
  sdr_stat_t stat;
  logic [3:0] rg;                           // Group that gives the spare
  logic      ownFree;
  logic      otherFound;
  logic [3:0] otherGrp;
  sdr_addr_t replAddr;
  always_comb begin
    act        = ACT_NONE;
    stat       = ST_DONE;
    ownFree    = used[cmd.group] < SPARES_PER_GROUP;
    otherFound = 1'b0;
    otherGrp   = 4'h0;
    // First certified group with spares left, lowest index first
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (!otherFound && certified[g] && (4'(g) != cmd.group) && (used[g] < SPARES_PER_GROUP)) begin
        otherFound = 1'b1;
        otherGrp   = 4'(g);
      end
    end
    rg       = ownFree ? cmd.group : otherGrp;
    replAddr = groupSpareBase[rg] + {20'h0, used[rg]};
    if (cmd.op == OP_CERT_DONE) begin
      stat = ST_DONE;
    end else if (|pdlHit) begin
      stat = ST_IN_PRIMARY;
    end else if (replTotal >= MAX_REPLACED) begin
      stat = ST_LIMIT;
    end else if ((cmd.op == OP_LOAD_PRIMARY || cmd.certifying) && ownFree) begin
      // Slip inside the group: data or spare sector, one spare gone
      if (pdlCount == 5'(PDL_DEPTH)) begin
        stat = ST_LIMIT;
      end else begin
        act  = ACT_PDL;
        stat = ST_SLIPPED;
      end
    end else if (|sdlKeyHit) begin
      // Original already redirected, never accessed again
      stat = ST_DONE;
    end else if (!ownFree && !otherFound) begin
      stat = ST_NO_SPARE;
    end else if (|sdlRepHit) begin
      act  = ACT_SDL_FIX;
      stat = ST_REREPLACED;
    end else if (sdlCount == 4'(SDL_DEPTH)) begin
      stat = ST_LIMIT;
    end else begin
      act  = ACT_SDL_NEW;
      stat = ST_LINEAR;
    end
  end

  // Primary list storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pdlCount <= 5'h0;
      for (int i = 0; i < PDL_DEPTH; i++) primary_defect_list[i] <= 32'hffffffff;
    end else if (cmdTaken && act == ACT_PDL) begin
      pdlCount <= pdlCount + 5'h1;
      for (int i = 0; i < PDL_DEPTH; i++) primary_defect_list[i] <= next_pdl[i];
    end
  end

  // Secondary list storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdlCount <= 4'h0;
      for (int i = 0; i < SDL_DEPTH; i++) begin
        sdlDef[i] <= 32'hffffffff;
        sdlRep[i] <= 32'hffffffff;
      end
    end else if (cmdTaken && act == ACT_SDL_NEW) begin
      sdlCount <= sdlCount + 4'h1;
      for (int i = 0; i < SDL_DEPTH; i++) begin
        sdlDef[i] <= next_sdlDef[i];
        // The inserted slot takes the fresh spare
        sdlRep[i] <= (next_sdlDef[i] == cmd.addr) ? replAddr : next_sdlRep[i];
      end
    end else if (cmdTaken && act == ACT_SDL_FIX) begin
      // Rewrite in place keeps the keys unique and sorted
      for (int i = 0; i < SDL_DEPTH; i++) begin
        if (sdlRepHit[i]) sdlRep[i] <= replAddr;
      end
    end
  end

  // Spare accounting, certification marks, replacement cap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      certified <= '0;
      replTotal <= 14'h0;
      for (int g = 0; g < NUM_GROUPS; g++) used[g] <= 12'h0;
    end else if (cmdTaken) begin
      if (cmd.op == OP_CERT_DONE) certified[cmd.group] <= 1'b1;
      if (act != ACT_NONE) begin
        used[rg]  <= used[rg] + 12'h1;
        replTotal <= replTotal + 14'h1;
      end
    end
  end

  // Command answer, one cycle after acceptance
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmdResp <= '0;
    end else begin
      cmdResp.valid <= cmdTaken;
      if (cmdTaken) begin
        cmdResp.stat <= stat;
        cmdResp.repl <= (act == ACT_SDL_NEW || act == ACT_SDL_FIX) ? replAddr : cmd.addr;
      end
    end
  end

  // Translation walk: slip over primary entries, then secondary redirect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xState    <= X_IDLE;
      cur       <= 32'h0;
      idx       <= 5'h0;
      busy      <= 1'b0;
      xlateResp <= '0;
    end else begin
      xlateResp.valid <= 1'b0;
      case (xState)
        X_IDLE: begin
          if (xlateTaken) begin
            cur    <= xlateReq.addr;
            idx    <= 5'h0;
            busy   <= 1'b1;
            xState <= X_WALK;
          end
        end
        X_WALK: begin
          // Ascending order lets one pass count every earlier defect
          if (idx < pdlCount) begin
            if (primary_defect_list[idx[3:0]] <= cur) cur <= cur + 32'h1;
            idx <= idx + 5'h1;
          end else begin
            xState <= X_SDL;
          end
        end
        X_SDL: begin
          xlateResp.valid <= 1'b1;
          xlateResp.addr  <= cur;
          for (int j = 0; j < SDL_DEPTH; j++) begin
            if (curHit[j]) xlateResp.addr <= sdlRep[j];
          end
          busy   <= 1'b0;
          xState <= X_IDLE;
        end
        default: begin
          xState <= X_IDLE;
          busy   <= 1'b0;
        end
      endcase
    end
  end

  // List image byte generator
  logic [15:0] b;
  logic [15:0] rel;
  logic [15:0] ent;
  logic [15:0] lenBytes;
  logic [15:0] endByte;
  logic [7:0]  byteOut;
  sdr_addr_t   word;
  always_comb begin
    b    = imgReq.offset;
    word = 32'h0;
    if (!imgReq.selSecondary) begin
      lenBytes = PDL_HDR_BYTES + ({11'h0, pdlCount} << PDL_ENT_SHIFT);
      rel      = b - PDL_HDR_BYTES;
      ent      = rel >> PDL_ENT_SHIFT;
      word     = primary_defect_list[ent[3:0]];
      if (b == 16'h0) byteOut = PDL_ID0;
      else if (b == 16'h1) byteOut = PDL_ID1;
      else if (b == 16'h2) byteOut = ZERO_BYTE;  // Count high byte, list is small
      else if (b == 16'h3) byteOut = {3'h0, pdlCount};
      else if (ent < {11'h0, pdlCount}) byteOut = 8'(word >> {~rel[1:0], 3'h0});
      else byteOut = PAD_BYTE;
    end else begin
      lenBytes = SDL_HDR_BYTES + ({12'h0, sdlCount} << SDL_ENT_SHIFT);
      rel      = b - SDL_HDR_BYTES;
      ent      = rel >> SDL_ENT_SHIFT;
      word     = rel[2] ? sdlRep[ent[2:0]] : sdlDef[ent[2:0]];
      if (b < 16'h4) byteOut = 8'(SDL_ID >> {~b[1:0], 3'h0});
      else if (b < 16'h6) byteOut = ZERO_BYTE;  // Length bits 8 and up, list is small
      else if (b == 16'h6) byteOut = 8'({12'h0, sdlCount} << SDL_ENT_SHIFT);
      else if (b < 16'ha) byteOut = 8'(SDL_FIXED >> {4'(16'h9 - b), 3'h0});
      else if (b < 16'he) byteOut = ZERO_BYTE;
      else if (b == 16'he) byteOut = ZERO_BYTE;
      else if (b == 16'hf) byteOut = {4'h0, sdlCount};
      else if (ent < {12'h0, sdlCount}) byteOut = 8'(word >> {~rel[1:0], 3'h0});
      else byteOut = PAD_BYTE;
    end
    // Last byte of the last sector the list needs, header only once
    endByte = (((lenBytes + SECTOR_BYTES - 16'h1) >> SECTOR_SHIFT) << SECTOR_SHIFT) - 16'h1;
  end

  // Image answer registered one cycle after the request
  logic [15:0] imgOffQ;
  logic        imgSelQ;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      imgResp <= '0;
      imgOffQ <= 16'h0;
      imgSelQ <= 1'b0;
    end else begin
      imgResp.valid <= imgReq.valid;
      imgResp.data  <= byteOut;
      imgResp.last  <= imgReq.valid && (b == endByte);
      imgOffQ       <= b;
      imgSelQ       <= imgReq.selSecondary;
    end
  end

  // Checks
  logic pdlSorted;
  logic sdlSorted;
  logic physInPdl;
  always_comb begin
    pdlSorted = 1'b1;
    sdlSorted = 1'b1;
    physInPdl = 1'b0;
    for (int i = 1; i < PDL_DEPTH; i++) begin
      if (5'(i) < pdlCount && primary_defect_list[i-1] >= primary_defect_list[i]) pdlSorted = 1'b0;
    end
    for (int i = 1; i < SDL_DEPTH; i++) begin
      if (4'(i) < sdlCount && sdlDef[i-1] >= sdlDef[i]) sdlSorted = 1'b0;
    end
    for (int i = 0; i < PDL_DEPTH; i++) begin
      if (5'(i) < pdlCount && primary_defect_list[i] == xlateResp.addr) physInPdl = 1'b1;
    end
  end

  property p_pdl_sorted;
    @(posedge clk) disable iff (!nrst) pdlSorted;
  endproperty
  a_pdl_sorted: assert property (p_pdl_sorted) else $error("primary list out of order");

  property p_sdl_sorted;
    @(posedge clk) disable iff (!nrst) sdlSorted;
  endproperty
  a_sdl_sorted: assert property (p_sdl_sorted) else $error("secondary list out of order");

  property p_slip_grows;
    @(posedge clk) disable iff (!nrst) cmdTaken && act == ACT_PDL |=> pdlCount == $past(pdlCount) + 5'h1
      ##0 cmdResp.valid && cmdResp.stat == ST_SLIPPED;
  endproperty
  a_slip_grows: assert property (p_slip_grows) else $error("slip did not add a primary entry");

  property p_no_dup;
    @(posedge clk) disable iff (!nrst) cmdTaken && cmd.op != OP_CERT_DONE && (|pdlHit) |=> $stable(sdlCount) && $stable(pdlCount)
      && cmdResp.stat == ST_IN_PRIMARY;
  endproperty
  a_no_dup: assert property (p_no_dup) else $error("primary address entered a list again");

  property p_cap;
    @(posedge clk) disable iff (!nrst) replTotal <= MAX_REPLACED;
  endproperty
  a_cap: assert property (p_cap) else $error("replacement total above cap");

  property p_borrow_certified;
    @(posedge clk) disable iff (!nrst) cmdTaken && act == ACT_SDL_NEW && rg != cmd.group |-> certified[rg];
  endproperty
  a_borrow_certified: assert property (p_borrow_certified) else $error("spare taken from uncertified group");

  property p_xlate_time;
    @(posedge clk) disable iff (!nrst) xlateTaken |=> busy ##[1:18] xlateResp.valid;
  endproperty
  a_xlate_time: assert property (p_xlate_time) else $error("translation answer late");

  property p_phys_good;
    @(posedge clk) disable iff (!nrst) xlateResp.valid |-> !physInPdl;
  endproperty
  a_phys_good: assert property (p_phys_good) else $error("translation hit a defective sector");

  property p_pdl_header;
    @(posedge clk) disable iff (!nrst) imgResp.valid && !imgSelQ && imgOffQ == 16'h1 |-> imgResp.data == PDL_ID1;
  endproperty
  a_pdl_header: assert property (p_pdl_header) else $error("primary identifier wrong");

  c_slip: cover property (@(posedge clk) disable iff (!nrst) cmdTaken && act == ACT_PDL);
  c_linear: cover property (@(posedge clk) disable iff (!nrst) cmdTaken && act == ACT_SDL_NEW);
  c_fix: cover property (@(posedge clk) disable iff (!nrst) cmdTaken && act == ACT_SDL_FIX);
  c_redirect: cover property (@(posedge clk) disable iff (!nrst) xState == X_SDL && (|curHit));
endmodule
